/* File: rtl/board_indicator.sv */
// Board LEDs, board ID jumpers and AXI4-Lite register slave
`timescale 1ns/1ns
module board_indicator #(
	parameter logic [7:0]  FW_REV         = 8'h5A, // Arbitrary revision value
	parameter int unsigned FLASH_HALF_CYC = board_pkg::FLASH_HALF_CYC,
	parameter int unsigned FLASH_TOGGLES  = board_pkg::FLASH_TOGGLES
) (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic [board_pkg::ADDR_W-1:0]      awaddr,
	input  wire logic [2:0]                        awprot,
	input  wire logic                              awvalid,
	output logic                                   awready,
	input  wire logic [31:0]                       wdata,
	input  wire logic [3:0]                        wstrb,
	input  wire logic                              wvalid,
	output logic                                   wready,
	output logic [1:0]                             bresp,
	output logic                                   bvalid,
	input  wire logic                              bready,
	input  wire logic [board_pkg::ADDR_W-1:0]      araddr,
	input  wire logic [2:0]                        arprot,
	input  wire logic                              arvalid,
	output logic                                   arready,
	output logic [31:0]                            rdata,
	output logic [1:0]                             rresp,
	output logic                                   rvalid,
	input  wire logic                              rready,
	input  wire logic [board_pkg::ID_W-1:0]        board_id_jumper_block,
	output logic                                   board_led_red,
	output logic                                   board_led_green,
	output logic [board_pkg::N_CH-1:0]             pair_led_red,
	output logic [board_pkg::N_CH-1:0]             pair_led_green,
	output logic [1:0]                             firmware_status_leds
);
	localparam int unsigned NC = board_pkg::N_CH;

	function automatic logic [2:0] decode(input logic [board_pkg::ADDR_W-1:0] a);
		logic [2:0] s;
		s = board_pkg::SEL_NONE;
		if (a[7:2] == board_pkg::OFF_BRD_CTRL[7:2])
			s = board_pkg::SEL_CTRL;
		else if (a[7:2] == board_pkg::OFF_BRD_STAT[7:2])
			s = board_pkg::SEL_STAT;
		else if (a[7:4] == board_pkg::CH_PAGE)
			s = board_pkg::SEL_CH;
		return s;
	endfunction : decode

	// Jumper synchroniser, first stage read only by the second
	logic [board_pkg::ID_W-1:0] id_s1_r;
	logic [board_pkg::ID_W-1:0] id_s2_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			id_s1_r <= '0;
			id_s2_r <= '0;
		end
		else
		begin
			id_s1_r <= board_id_jumper_block;
			id_s2_r <= id_s1_r;
		end
	end

	// Register file and write channel
	logic                aw_hold_r, aw_hold_nxt;
	logic                w_hold_r, w_hold_nxt;
	logic [7:0]          wa_r, wa_nxt;
	logic [31:0]         wd_r, wd_nxt;
	logic [3:0]          ws_r, ws_nxt;
	logic                awready_r, awready_nxt;
	logic                wready_r, wready_nxt;
	logic                bvalid_r, bvalid_nxt;
	logic [1:0]          bresp_r, bresp_nxt;
	logic                brd_red_r, brd_red_nxt;
	logic                brd_grn_r, brd_grn_nxt;
	logic [NC-1:0][3:0]  ch_led_r, ch_led_nxt;

	always_comb
	begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		wa_nxt      = wa_r;
		wd_nxt      = wd_r;
		ws_nxt      = ws_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		brd_red_nxt = brd_red_r;
		brd_grn_nxt = brd_grn_r;
		ch_led_nxt  = ch_led_r;
		if (awvalid && awready_r)
		begin
			aw_hold_nxt = 1'b1;
			wa_nxt      = awaddr;
		end
		if (wvalid && wready_r)
		begin
			w_hold_nxt = 1'b1;
			wd_nxt     = wdata;
			ws_nxt     = wstrb;
		end
		if (bvalid_r && bready)
			bvalid_nxt = 1'b0;
		if (aw_hold_nxt && w_hold_nxt && !bvalid_r)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = board_pkg::RESP_OKAY;
			unique case (decode(wa_nxt))
				board_pkg::SEL_CTRL:
				begin
					if (ws_nxt[board_pkg::CTRL_LANE])
					begin
						brd_red_nxt = wd_nxt[board_pkg::BRD_RED_BIT];
						brd_grn_nxt = wd_nxt[board_pkg::BRD_GRN_BIT];
					end
				end
				board_pkg::SEL_CH:
				begin
					if (ws_nxt[board_pkg::CH_LANE])
						ch_led_nxt[wa_nxt[3:2]] = wd_nxt[board_pkg::CH_LED_LSB +: 4];
				end
				board_pkg::SEL_STAT:
				begin
					bresp_nxt = board_pkg::RESP_OKAY;
				end
				default:
				begin
					bresp_nxt = board_pkg::RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = !aw_hold_nxt && !bvalid_nxt;
		wready_nxt  = !w_hold_nxt && !bvalid_nxt;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			wa_r      <= 8'h00;
			wd_r      <= 32'h0000_0000;
			ws_r      <= 4'h0;
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			bvalid_r  <= 1'b0;
			bresp_r   <= board_pkg::RESP_OKAY;
			brd_red_r <= 1'b0;
			brd_grn_r <= 1'b0;
			ch_led_r  <= '0;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			wa_r      <= wa_nxt;
			wd_r      <= wd_nxt;
			ws_r      <= ws_nxt;
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			brd_red_r <= brd_red_nxt;
			brd_grn_r <= brd_grn_nxt;
			ch_led_r  <= ch_led_nxt;
		end
	end

	// Read channel
	logic        arready_r, arready_nxt;
	logic        rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0]  rresp_r, rresp_nxt;

	always_comb
	begin
		arready_nxt = arready_r;
		rvalid_nxt  = rvalid_r;
		rdata_nxt   = rdata_r;
		rresp_nxt   = rresp_r;
		if (rvalid_r && rready)
		begin
			rvalid_nxt  = 1'b0;
			arready_nxt = 1'b1;
		end
		if (arvalid && arready_r)
		begin
			arready_nxt = 1'b0;
			rvalid_nxt  = 1'b1;
			rdata_nxt   = 32'h0000_0000;
			rresp_nxt   = board_pkg::RESP_OKAY;
			unique case (decode(araddr))
				board_pkg::SEL_CTRL:
				begin
					rdata_nxt[board_pkg::BRD_RED_BIT] = brd_red_r;
					rdata_nxt[board_pkg::BRD_GRN_BIT] = brd_grn_r;
				end
				board_pkg::SEL_STAT:
				begin
					rdata_nxt[board_pkg::ID_W-1:0] = id_s2_r;
				end
				board_pkg::SEL_CH:
				begin
					rdata_nxt[board_pkg::CH_LED_LSB +: 4] = ch_led_r[araddr[3:2]];
				end
				default:
				begin
					rresp_nxt = board_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= board_pkg::RESP_OKAY;
		end
		else
		begin
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	// LED drive
	logic [NC-1:0] p_red_r, p_red_nxt;
	logic [NC-1:0] p_grn_r, p_grn_nxt;
	logic          b_red_r, b_grn_r;

	always_comb
	begin
		logic [3:0] f;
		logic       all_zero;
		f        = 4'h0;
		all_zero = (ch_led_r == '0);
		for (int i = 0; i < NC; i++)
		begin
			f            = ch_led_r[NC-1-i];
			p_red_nxt[i] = f[3] && f[2];
			p_grn_nxt[i] = f[1] ? f[0] : (all_zero && FW_REV[i]);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p_red_r <= '0;
			p_grn_r <= '0;
			b_red_r <= 1'b0;
			b_grn_r <= 1'b0;
		end
		else
		begin
			p_red_r <= p_red_nxt;
			p_grn_r <= p_grn_nxt;
			b_red_r <= brd_red_r;
			b_grn_r <= brd_grn_r;
		end
	end

	status_flasher #(
		.HALF_CYC (FLASH_HALF_CYC),
		.TOGGLES  (FLASH_TOGGLES)
	) u_flasher (
		.clk   (clk),
		.rst_n (rst_n),
		.leds  (firmware_status_leds)
	);

	assign awready         = awready_r;
	assign wready          = wready_r;
	assign bvalid          = bvalid_r;
	assign bresp           = bresp_r;
	assign arready         = arready_r;
	assign rvalid          = rvalid_r;
	assign rdata           = rdata_r;
	assign rresp           = rresp_r;
	assign board_led_red   = b_red_r;
	assign board_led_green = b_grn_r;
	assign pair_led_red    = p_red_r;
	assign pair_led_green  = p_grn_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	id_sync_a: assert property (rst_n ##2 1'b1 |-> id_s2_r == $past(board_id_jumper_block, 2))
		else $error("board status ID bits do not follow jumpers");
	id_read_a: assert property (arvalid && arready_r && decode(araddr) == board_pkg::SEL_STAT
		|=> rvalid && rdata[3:0] == $past(id_s2_r) && rdata[31:4] == 28'h0)
		else $error("board status read returned wrong ID bits");
	brd_led_a: assert property (##1 board_led_red == $past(brd_red_r) && board_led_green == $past(brd_grn_r))
		else $error("board LED pair does not follow board control");
	red_on_a: assert property (ch_led_r[NC-1][3:2] == board_pkg::LED_ON |=> pair_led_red[0])
		else $error("channel 4 red code 11 did not light first pair");
	red_off_a: assert property (ch_led_r[0][3:2] == board_pkg::LED_OFF |=> !pair_led_red[NC-1])
		else $error("channel 1 red code 10 did not darken last pair");
	grn_code_a: assert property (ch_led_r[1][1] |=> pair_led_green[2] == $past(ch_led_r[1][0]))
		else $error("channel 2 green code not shown on third pair");
	rev_show_a: assert property (rst_n && ch_led_r == '0 |=> pair_led_green == FW_REV[NC-1:0])
		else $error("revision bits not displayed with fields clear");
	grn_quiet_a: assert property (ch_led_r != '0 && !ch_led_r[NC-1][1] |=> !pair_led_green[0])
		else $error("first pair green lit with upper code bit clear");
	bad_addr_a: assert property (aw_hold_r && w_hold_r && !bvalid_r && decode(wa_r) == board_pkg::SEL_NONE
		|=> bvalid && bresp == board_pkg::RESP_SLVERR)
		else $error("unmapped write not answered with error");

	wr_done_c: cover property (bvalid && bready && bresp == board_pkg::RESP_OKAY);
	rd_done_c: cover property (rvalid && rready);
	rev_off_c: cover property (ch_led_r == '0 ##1 ch_led_r != '0);
endmodule : board_indicator

/* File: rtl/board_pkg.sv */
// Constants for the board indicator and identification logic
package board_pkg;
	localparam int unsigned N_CH     = 4;
	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned ID_W     = 4;

	localparam logic [7:0] OFF_BRD_CTRL = 8'h00;
	localparam logic [7:0] OFF_BRD_STAT = 8'h04;
	localparam logic [7:0] OFF_CH_CTRL1 = 8'h10;
	localparam logic [3:0] CH_PAGE      = 4'h1;

	localparam int unsigned BRD_RED_BIT = 25;
	localparam int unsigned BRD_GRN_BIT = 24;
	localparam int unsigned CH_LED_LSB  = 20;
	localparam int unsigned CTRL_LANE   = 3;
	localparam int unsigned CH_LANE     = 2;

	localparam logic [1:0] LED_OFF = 2'h2;
	localparam logic [1:0] LED_ON  = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [2:0] SEL_CTRL = 3'h0;
	localparam logic [2:0] SEL_STAT = 3'h1;
	localparam logic [2:0] SEL_CH   = 3'h2;
	localparam logic [2:0] SEL_NONE = 3'h7;

	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned FLASH_HALF_MS = 250;
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_TOGGLES  = 8;

	localparam logic [1:0] FW_LEDS_ON  = 2'h3;
	localparam logic [1:0] FW_LEDS_OFF = 2'h0;
endpackage : board_pkg

/* File: rtl/status_flasher.sv */
// Firmware status LED flasher run once after reset
`timescale 1ns/1ns
module status_flasher #(
	parameter int unsigned HALF_CYC = board_pkg::FLASH_HALF_CYC,
	parameter int unsigned TOGGLES  = board_pkg::FLASH_TOGGLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	output logic      [1:0] leds
);
	typedef enum logic {FLASHING, QUIET} flash_state_t;

	flash_state_t state_r;
	flash_state_t state_nxt;
	logic [31:0]  cnt_r;
	logic [31:0]  cnt_nxt;
	logic [7:0]   tog_r;
	logic [7:0]   tog_nxt;
	logic [1:0]   leds_r;
	logic [1:0]   leds_nxt;

	assign leds = leds_r;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		tog_nxt   = tog_r;
		leds_nxt  = leds_r;
		unique case (state_r)
			FLASHING:
			begin
				if (cnt_r == 32'(HALF_CYC - 1))
				begin
					cnt_nxt  = 32'h0;
					leds_nxt = ~leds_r;
					tog_nxt  = tog_r + 8'h1;
					if (tog_r == 8'(TOGGLES - 1))
					begin
						state_nxt = QUIET;
						leds_nxt  = board_pkg::FW_LEDS_OFF;
					end
				end
				else
				begin
					cnt_nxt = cnt_r + 32'h1;
				end
			end
			QUIET:
			begin
				leds_nxt = board_pkg::FW_LEDS_OFF;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= FLASHING;
			cnt_r   <= 32'h0;
			tog_r   <= 8'h0;
			leds_r  <= board_pkg::FW_LEDS_ON;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			tog_r   <= tog_nxt;
			leds_r  <= leds_nxt;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	quiet_off_a: assert property (state_r == QUIET |=> leds_r == board_pkg::FW_LEDS_OFF)
		else $error("status LEDs lit after flashing ended");
	quiet_stays_a: assert property (state_r == QUIET |=> state_r == QUIET)
		else $error("flasher left quiet state");
	flash_hold_a: assert property (state_r == FLASHING && cnt_r != 32'(HALF_CYC - 1) |=> $stable(leds_r))
		else $error("status LEDs changed mid half period");
	quiet_seen_c: cover property (state_r == FLASHING ##1 state_r == QUIET);
endmodule : status_flasher

/* File: tb/board_indicator_and_id_logic_test.sv */
// Self-checking bench for the board indicator and ID logic
`timescale 1ns/1ns
module board_indicator_and_id_logic_test;
	localparam logic [7:0] REV = 8'h5A;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, jmp, p_red, p_grn;
	logic        awready, wready, bvalid, arready, rvalid, b_red, b_grn;
	logic [1:0]  bresp, rresp, fw;
	int          n_fail, check_count;

	board_indicator #(.FW_REV(REV), .FLASH_HALF_CYC(4), .FLASH_TOGGLES(4)) DUT (
		.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .board_id_jumper_block(jmp),
		.board_led_red(b_red), .board_led_green(b_grn), .pair_led_red(p_red), .pair_led_green(p_grn),
		.firmware_status_leds(fw));

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic fail_to();
		n_fail++;
		$display("Error at %0t: timeout got %h expected %h", $time, 1'b0, 1'b1);
		end_sim();
	endtask : fail_to

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
	endtask : do_reset

	// Outputs follow a register write by one cycle
	task automatic settle();
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic ta, tw, tb;
		int   i;
		resp = 2'h1;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bready && bvalid;
			if (tb)
				resp = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb)
			begin
				bready <= 1'b0;
				return;
			end
		end
		fail_to();
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ta, tr;
		int   i;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(negedge clk);
			ta = arvalid && arready;
			tr = rready && rvalid;
			d = rdata;
			resp = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			if (tr)
			begin
				rready <= 1'b0;
				return;
			end
		end
		fail_to();
	endtask : axi_read

	task automatic test_revision();
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(32'(p_grn), 32'(REV[3:0]));
		chk(32'({b_red, b_grn, p_red}), 32'h0);
		$display("test_revision done");
	endtask : test_revision

	task automatic test_jumper();
		logic [3:0]  pats [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6};
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk);
			jmp <= pats[i];
			repeat (4) @(posedge clk);
			axi_read(8'h04, d, r);
			chk(d, {28'h0, pats[i]});
		end
		axi_write(8'h04, 32'h0000000F, 4'hF, r);
		axi_read(8'h04, d, r);
		chk(d, {28'h0, pats[4]});
		$display("test_jumper done");
	endtask : test_jumper

	task automatic test_board_led();
		logic [31:0] d;
		logic [1:0]  r;
		for (int c = 0; c < 4; c++)
		begin
			axi_write(8'h00, {6'h0, 2'(c), 24'h0}, 4'hF, r);
			settle();
			chk(32'({b_red, b_grn}), 32'(c));
			chk(32'(r), 32'h0);
			axi_read(8'h00, d, r);
			chk(d, {6'h0, 2'(c), 24'h0});
			chk(32'(r), 32'h0);
		end
		axi_write(8'h00, 32'h0, 4'h7, r);
		settle();
		chk(32'({b_red, b_grn}), 32'h3);
		$display("test_board_led done");
	endtask : test_board_led

	task automatic test_channel();
		logic [3:0]  exp;
		logic [31:0] d;
		logic [1:0]  r;
		exp = 4'h0;
		for (int k = 0; k < 4; k++)
		begin
			axi_write(8'h10 + 8'(4 * k), 32'h00F00000, 4'hF, r);
			exp[3 - k] = 1'b1;
			settle();
			chk(32'(p_red), 32'(exp));
			chk(32'(p_grn), 32'(exp));
		end
		for (int k = 0; k < 4; k++)
		begin
			axi_write(8'h10 + 8'(4 * k), 32'h00A00000, 4'hF, r);
			exp[3 - k] = 1'b0;
			settle();
			chk(32'(p_red), 32'(exp));
			chk(32'(p_grn), 32'(exp));
		end
		axi_read(8'h1C, d, r);
		chk(d, 32'h00A00000);
		// Lane 2 clear: channel field must stay put
		axi_write(8'h1C, 32'h00F00000, 4'hB, r);
		settle();
		chk(32'(p_red), 32'h0);
		axi_write(8'h1C, 32'h00500000, 4'hF, r);
		settle();
		chk(32'(p_red), 32'h0);
		chk(32'(p_grn), 32'h0);
		for (int k = 0; k < 4; k++)
			axi_write(8'h10 + 8'(4 * k), 32'h0, 4'hF, r);
		settle();
		chk(32'(p_grn), 32'(REV[3:0]));
		$display("test_channel done");
	endtask : test_channel

	task automatic test_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		axi_write(8'h40, 32'hFFFFFFFF, 4'hF, r);
		chk(32'(r), 32'h2);
		axi_read(8'h40, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'h2);
		$display("test_unmapped done");
	endtask : test_unmapped

	task automatic test_flash();
		int         chg, quiet;
		logic [1:0] last;
		do_reset();
		@(negedge clk);
		chk(32'(fw), 32'h3);
		last = fw;
		chg = 0;
		quiet = 0;
		for (int i = 0; i < 80; i++)
		begin
			@(negedge clk);
			if (fw !== last)
			begin
				chg++;
				quiet = 0;
			end
			else
				quiet++;
			last = fw;
		end
		chk(32'(fw), 32'h0);
		chk(32'(chg >= 2), 32'h1);
		chk(32'(quiet >= 30), 32'h1);
		$display("test_flash done");
	endtask : test_flash

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		rst_n = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		jmp = 4'h0;
		n_fail = 0;
		check_count = 0;
		do_reset();
		test_revision();
		test_jumper();
		test_board_led();
		test_channel();
		test_unmapped();
		test_flash();
		end_sim();
	end
endmodule : board_indicator_and_id_logic_test
